//--- dv/spe_eeprom_command_protect_tb.sv
// Self-checking bench for the serial EEPROM command block.
// Assumes spe_host as bus master and a shortened write time.
`timescale 1ns/1ps
`default_nettype none

module spe_eeprom_command_protect_tb;
	logic        mclk;      // System clock
	logic        resetn;    // Reset, active low
	logic        wp_n;      // Write protect pin
	wire         cs_n;      // Select
	wire         sck;       // Serial clock
	wire         si;        // Serial in
	wire         so;        // Serial out
	wire         so_oe_n;   // Output enable, active low
	int          n_fail;    // Mismatches
	int          n_tests;   // Comparisons
	// Rows: command bytes, byte count, status after
	logic [15:0] t_cmd[7] = '{16'h0600, 16'h0400, 16'h0e00, 16'h0c00, 16'h0600, 16'h4000, 16'h0455};
	int          t_len[7] = '{1, 1, 1, 1, 2, 1, 2};
	logic [7:0]  t_sr[7]  = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h02, 8'h00};

	spe_eeprom_top #(.TW_CYCLES(2000)) dut (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
		.wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));
	spe_host host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));

	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic go(input logic [7:0] q[$], input int nrx);
		host.txq = q;
		host.frame(nrx);
	endtask

	// Two status bytes in one frame
	task automatic sr(input logic [7:0] exp);
		go({8'h05}, 2);
		check("status", exp, host.rxq[0]);
		check("status repeat", exp, host.rxq[1]);
	endtask

	// Poll until ready, bounded
	task automatic wready();
		int i;
		for (i = 0; i < 40; i++)
		begin
			go({8'h05}, 1);
			if (host.rxq[0][0] === 1'b0)
				break;
		end
		if (i == 40)
		begin
			n_fail++;
			report_and_stop();
		end
	endtask

	task automatic rd(input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1);
		go({8'h03, a[23:16], a[15:8], a[7:0]}, 2);
		check("read first", e0, host.rxq[0]);
		check("read next", e1, host.rxq[1]);
	endtask

	task automatic wr(input logic [23:0] a, input logic [7:0] d[$]);
		host.txq = {8'h02, a[23:16], a[15:8], a[7:0], d};
		host.frame(0);
	endtask

	// Watchdog
	initial
	begin
		repeat (100000) @(posedge mclk);
		n_fail++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		n_fail  = 0;
		n_tests = 0;
		resetn  = 1'b0;
		wp_n    = 1'b1;
		repeat (20) @(posedge mclk);
		#2;
		resetn = 1'b1;
		repeat (4) @(posedge mclk);
		#2;
		check("oe idle", 8'h01, {7'h0, so_oe_n});
		sr(8'h00);
		for (int r = 0; r < 7; r++)
		begin
			host.txq = {t_cmd[r][15:8]};
			if (t_len[r] == 2)
				host.txq.push_back(t_cmd[r][7:0]);
			host.frame(0);
			sr(t_sr[r]);
		end
		go({8'h40}, 1);
		check("unknown drive", 8'h00, {7'h0, host.drv});
		// Status write with pin low, enable clear
		wp_n = 1'b0;
		go({8'h06}, 0);
		go({8'h01, 8'hfc}, 0);
		sr(8'hff);
		go({8'h03, 8'h00, 8'h00, 8'h00}, 1);
		check("busy read drive", 8'h00, {7'h0, host.drv});
		wready();
		sr(8'h8c);
		go({8'h06}, 0);
		go({8'h01, 8'h00}, 0);
		sr(8'h8e);
		wp_n = 1'b1;
		go({8'h01, 8'h00}, 0);
		wready();
		sr(8'h00);
		// Page wrap and address width
		go({8'h06}, 0);
		wr(24'hfc01fe, {8'haa, 8'hbb, 8'hcc, 8'hdd});
		wready();
		rd(24'h0001fe, 8'haa, 8'hbb);
		rd(24'h000100, 8'hcc, 8'hdd);
		go({8'h06}, 0);
		wr(24'h03ffff, {8'h5a});
		wready();
		go({8'h06}, 0);
		wr(24'h000000, {8'ha5});
		wready();
		rd(24'h03ffff, 8'h5a, 8'ha5);
		wr(24'h000000, {8'h33});
		wready();
		rd(24'h03ffff, 8'h5a, 8'ha5);
		// Id page, lock status and ignored id write
		go({8'h8b, 8'h00, 8'h00, 8'h00}, 1);
		check("id read", spe_pkg::ID_FILL, host.rxq[0]);
		go({8'h83, 8'h00, 8'h04, 8'h00}, 1);
		check("lock status", spe_pkg::LOCK_STAT, host.rxq[0]);
		go({8'h06}, 0);
		go({8'h82, 8'h00, 8'h00, 8'h00, 8'h12}, 0);
		sr(8'h02);
		// Quarter protection
		go({8'h06}, 0);
		go({8'h01, 8'h04}, 0);
		wready();
		sr(8'h04);
		go({8'h06}, 0);
		wr(24'h03ffff, {8'h77});
		wready();
		rd(24'h03ffff, 8'h5a, 8'ha5);
		sr(8'h04);
		report_and_stop();
	end
endmodule // spe_eeprom_command_protect_tb

`default_nettype wire

//--- dv/spe_host.sv
// Host serial master model: drives select, clock and data, captures output.
// Assumes mclk is the device clock; every pin change follows its rising edge.
`timescale 1ns/1ps
`default_nettype none

module spe_host (
	// Clock
	input  wire logic mclk,
	// Serial pins
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe_n
);
	logic [7:0] txq[$];   // Bytes to send
	logic [7:0] rxq[$];   // Bytes captured
	logic       drv;      // Output enabled in frame

	// Idle pins
	initial
	begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// Half period of four mclk, so the serial clock runs at 320 ns
	task automatic half();
		repeat (4) @(posedge mclk);
		#2;
	endtask

	// One bit: data set in low phase, output sampled at end of high phase
	task automatic bit_x(input logic d, output logic q);
		si  = d;
		half();
		sck = 1'b1;
		half();
		// Device output lags its filtered fall by one mclk, five after sck falls; a released pin reads inverted
		q   = so_oe_n ? ~so : so;
		drv = drv | ~so_oe_n;
		sck = 1'b0;
	endtask

	// Whole frame: command bytes out, then nrx bytes in
	task automatic frame(input int nrx);
		logic [7:0] b;
		rxq.delete();
		drv = 1'b0;
		@(posedge mclk);
		#2;
		cs_n = 1'b0;
		half();
		foreach (txq[i])
			for (int k = 7; k >= 0; k--)
				bit_x(txq[i][k], b[k]);
		for (int j = 0; j < nrx; j++)
		begin
			for (int k = 7; k >= 0; k--)
				bit_x(~si, b[k]);
			rxq.push_back(b);
		end
		half();
		cs_n = 1'b1;
		si   = ~si;
		half();
	endtask
endmodule // spe_host

`default_nettype wire

//--- hw/spe_eeprom_top.sv
// Serial EEPROM instruction logic: decode, latch, status, protection, read and page write.
// Assumes pins arrive asynchronously; serial clock is sampled by mclk at least 8x faster.
//
// Overview of operation
// - Status reads all ones during write cycle
// - Protect bits map to protected address range
// - Opcode sampled on rising edges, MSB first
// - Output changes on falling edges, MSB first
// - Select rise ends transaction, starts operation
// - Decode latch set, clear, status read
// - Decode status write, array read, write
// - Id opcodes split by address bit ten; only id read split, id write ignored
// - 24-bit address, low 18 bits used
// - Id page bit ten low, lock high
// - Latch cleared at reset and completions
// - Latch set; 16-clock forms accepted
// - Only status read accepted while busy
// - Status repeats while clocking continues
// - Status write keeps only protect fields
// - Status write needs latch, no pin protect
// - Status fields update at write completion
// - Sequential read wraps to address zero
// - Page write wraps, keeps last 256
// - Protected bytes never written, others need latch
// - Protect pin ignored for array writes
// - Pin protect is low pin with enable
`timescale 1ns/1ps
`default_nettype none

module spe_eeprom_top #(
	parameter int TW_CYCLES = spe_pkg::TW_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic resetn,
	// Serial pins
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic wp_n,
	// Serial output and its enable
	output logic      so,
	output logic      so_oe_n
);

	localparam int BW = $clog2(TW_CYCLES + 1);

	// ****************************************
	// Pin synchronisation and storage
	// ****************************************
	logic [3:0] pin_lvl, pin_rise, pin_fall;   // Filtered pins

	spe_sync #(.W(4)) u_sync (
		.clk    (mclk),
		.resetn (resetn),
		.din    ({wp_n, si, sck, cs_n}),
		.lvl    (pin_lvl),
		.rise   (pin_rise),
		.fall   (pin_fall)
	);

	spe_mem_if mif ();

	spe_mem #(.AW(spe_pkg::ADDR_W)) u_mem (
		.clk (mclk),
		.mp  (mif.mem)
	);

	// ****************************************
	// State
	// ****************************************
	spe_pkg::spe_state_e st, next_st;          // Transaction phase
	logic [2:0]          bitcnt, next_bitcnt;  // Input bit in byte
	logic [7:0]          shin, next_shin;      // Input shifter
	logic [7:0]          opc, next_opc;        // Captured opcode
	logic [1:0]          abytes, next_abytes;  // Address bytes taken
	logic [17:0]         addr, next_addr;      // Byte address
	logic [2:0]          obit, next_obit;      // Output bit in byte
	logic [6:0]          tx, next_tx;          // Output shifter
	logic                next_so, next_so_oe_n;
	logic                wel, next_wel;        // Write enable latch
	logic                protect_pin_enable, next_protect_pin_enable;      // Protect pin enable
	logic [1:0]          bp, next_bp;          // Block protect bits
	logic [2:0]          pend, next_pend;      // Pending status fields
	logic                have, next_have;      // Data byte received
	logic                busy, next_busy;      // Write cycle running
	logic                karr, next_karr;      // Write cycle is array kind
	logic [BW-1:0]       bcnt, next_bcnt;      // Write cycle countdown
	logic [8:0]          cidx, next_cidx;      // Commit index in page
	logic [7:0]          cval, next_cval;      // Constant read byte
	logic [255:0]        pval, next_pval;      // Page buffer valid bits
	logic [7:0]          pbuf [256];           // Page buffer
	logic                pb_we;                // Page buffer write

	// Derived terms
	logic       cs_act, sck_rise, sck_fall, byte_done, hwp;
	logic [7:0] in_byte, status_out, src;
	logic [17:0] full_addr;

	assign cs_act    = !pin_lvl[spe_pkg::PIN_CS];
	assign sck_rise  = cs_act && pin_rise[spe_pkg::PIN_SCK];
	assign sck_fall  = cs_act && pin_fall[spe_pkg::PIN_SCK];
	assign in_byte   = {shin[6:0], pin_lvl[spe_pkg::PIN_SI]};
	assign byte_done = sck_rise && bitcnt == 3'h7;
	assign full_addr = {addr[9:0], in_byte};
	assign hwp       = !pin_lvl[spe_pkg::PIN_WP] && protect_pin_enable;
	// All ones while busy, else live fields
	assign status_out = busy ? spe_pkg::SR_BUSY_VAL
		: {protect_pin_enable, 3'h0, bp, wel, 1'b0};

	// Storage hookup; reads follow the address pointer
	assign mif.raddr = addr;
	assign mif.waddr = {addr[17:8], cidx[7:0]};
	assign mif.wdata = pbuf[cidx[7:0]];
	// Commit only valid, unprotected bytes; pin protect not consulted
	assign mif.we    = busy && karr && !cidx[8] && pval[cidx[7:0]]
		&& !spe_pkg::spe_is_prot(mif.waddr, bp);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		next_st = st;       next_bitcnt = bitcnt; next_shin = shin;   next_opc = opc;
		next_abytes = abytes; next_addr = addr; next_obit = obit;    next_tx = tx;
		next_so = so;       next_so_oe_n = so_oe_n; next_wel = wel;   next_protect_pin_enable = protect_pin_enable;
		next_bp = bp;       next_pend = pend;     next_have = have;   next_busy = busy;
		next_karr = karr;   next_bcnt = bcnt;     next_cidx = cidx;   next_cval = cval;
		next_pval = pval;   pb_we = 1'b0;         src = status_out;
		// Write cycle progress and completion
		if (busy)
		begin
			next_bcnt = bcnt - BW'(1);
			if (!cidx[8])
			begin
				next_cidx = cidx + 9'h1;
			end
			if (bcnt == BW'(1))
			begin
				next_busy = 1'b0;
				next_wel  = 1'b0;
				if (!karr)
				begin
					{next_protect_pin_enable, next_bp} = pend;
				end
			end
		end
		// Transaction framing and shifting
		if (pin_fall[spe_pkg::PIN_CS])
		begin
			next_st     = spe_pkg::S_OPC;
			next_bitcnt = 3'h0;
			next_abytes = 2'h0;
			next_obit   = 3'h0;
			next_have   = 1'b0;
		end
		else if (pin_rise[spe_pkg::PIN_CS])
		begin
			// Select rise ends the frame; act only on byte boundary
			next_st      = spe_pkg::S_IDLE;
			next_so_oe_n = 1'b1;
			if (bitcnt == 3'h0 && !busy)
			begin
				unique case (st)
					spe_pkg::S_TAIL:
					begin
						// Latch commands, one or two bytes long
						if (spe_pkg::spe_cmd_of(opc) == spe_pkg::C_SET)
						begin
							next_wel = 1'b1;
						end
						else
						begin
							next_wel = 1'b0;
						end
					end
					spe_pkg::S_SWR:
					begin
						// Refused without latch or under pin protect
						if (have && wel && !hwp)
						begin
							next_busy = 1'b1;
							next_karr = 1'b0;
							next_bcnt = BW'(TW_CYCLES);
						end
					end
					spe_pkg::S_AWR:
					begin
						// Nothing changes without the latch
						if (have && wel)
						begin
							next_busy = 1'b1;
							next_karr = 1'b1;
							next_cidx = 9'h0;
							next_bcnt = BW'(TW_CYCLES);
						end
					end
					default:
					begin
					end
				endcase
			end
		end
		else if (cs_act)
		begin
			if (sck_rise)
			begin
				next_bitcnt = bitcnt + 3'h1;
				next_shin   = in_byte;
			end
			if (byte_done)
			begin
				unique case (st)
					spe_pkg::S_OPC:
					begin
						next_opc = in_byte;
						if (busy && spe_pkg::spe_cmd_of(in_byte) != spe_pkg::C_SRD)
						begin
							next_st = spe_pkg::S_IDLE;
						end
						else
						begin
							unique case (spe_pkg::spe_cmd_of(in_byte))
								spe_pkg::C_SET, spe_pkg::C_CLR: next_st = spe_pkg::S_TAIL;
								spe_pkg::C_SRD: next_st = spe_pkg::S_SRD;
								spe_pkg::C_SWR: next_st = spe_pkg::S_SWR;
								spe_pkg::C_ARD, spe_pkg::C_AWR,
								spe_pkg::C_IRD, spe_pkg::C_IWR: next_st = spe_pkg::S_ADDR;
								default: next_st = spe_pkg::S_IDLE;
							endcase
						end
						if (spe_pkg::spe_cmd_of(in_byte) == spe_pkg::C_AWR && !busy)
						begin
							next_pval = '0;
						end
					end
					spe_pkg::S_ADDR:
					begin
						next_addr   = full_addr;
						next_abytes = abytes + 2'h1;
						if (abytes == 2'h2)
						begin
							unique case (spe_pkg::spe_cmd_of(opc))
								spe_pkg::C_ARD: next_st = spe_pkg::S_ARD;
								spe_pkg::C_AWR: next_st = spe_pkg::S_AWR;
								spe_pkg::C_IRD:
								begin
									// Bit ten picks id page or lock status
									next_st   = spe_pkg::S_CRD;
									next_cval = addr[spe_pkg::A10_POS] ? spe_pkg::LOCK_STAT : spe_pkg::ID_FILL;
								end
								default: next_st = spe_pkg::S_IDLE;
							endcase
						end
					end
					spe_pkg::S_AWR:
					begin
						// Page buffer slot, address wraps within page
						pb_we                 = 1'b1;
						next_pval[addr[7:0]]  = 1'b1;
						next_addr[7:0]        = addr[7:0] + 8'h1;
						next_have             = 1'b1;
					end
					spe_pkg::S_SWR:
					begin
						// Only protect fields kept
						next_pend = {in_byte[spe_pkg::SR_PROTECT_PIN_ENABLE], in_byte[spe_pkg::SR_BP1],
							in_byte[spe_pkg::SR_BP0]};
						next_have = 1'b1;
					end
					spe_pkg::S_ARD:
					begin
						next_addr = addr + 18'h1;
					end
					default:
					begin
					end
				endcase
			end
			if (sck_fall && st inside {spe_pkg::S_SRD, spe_pkg::S_ARD, spe_pkg::S_CRD})
			begin
				// Pick source; status reloads every byte
				if (st == spe_pkg::S_ARD)
				begin
					src = mif.rdata;
				end
				else if (st == spe_pkg::S_CRD)
				begin
					src = cval;
				end
				next_so_oe_n = 1'b0;
				next_obit    = obit + 3'h1;
				if (obit == 3'h0)
				begin
					next_so = src[7];
					next_tx = src[6:0];
				end
				else
				begin
					next_so = tx[6];
					next_tx = {tx[5:0], 1'b1};
				end
			end
		end
	end

	// Registers
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= spe_pkg::S_IDLE; bitcnt <= 3'h0; shin <= 8'h00; opc <= 8'h00;
			abytes <= 2'h0; addr <= 18'h00000; obit <= 3'h0; tx <= 7'h00;
			so <= 1'b1; so_oe_n <= 1'b1; wel <= 1'b0; protect_pin_enable <= spe_pkg::PROTECT_PIN_ENABLE_RST;
			bp <= spe_pkg::BP_RST; pend <= 3'h0; have <= 1'b0; busy <= 1'b0;
			karr <= 1'b0; bcnt <= '0; cidx <= 9'h100; cval <= 8'h00; pval <= '0;
		end
		else
		begin
			st <= next_st; bitcnt <= next_bitcnt; shin <= next_shin; opc <= next_opc;
			abytes <= next_abytes; addr <= next_addr; obit <= next_obit; tx <= next_tx;
			so <= next_so; so_oe_n <= next_so_oe_n; wel <= next_wel; protect_pin_enable <= next_protect_pin_enable;
			bp <= next_bp; pend <= next_pend; have <= next_have; busy <= next_busy;
			karr <= next_karr; bcnt <= next_bcnt; cidx <= next_cidx; cval <= next_cval;
			pval <= next_pval;
		end
	end

	// Page buffer storage, last write to a slot wins
	always_ff @(posedge mclk)
	begin
		if (pb_we)
		begin
			pbuf[addr[7:0]] <= in_byte;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_cs_end;
		pin_rise[spe_pkg::PIN_CS] && bitcnt == 3'h0 && !busy;
	endsequence

	sequence s_opc_byte;
		byte_done && st == spe_pkg::S_OPC && !pin_fall[spe_pkg::PIN_CS];
	endsequence

	AST_BUSY_ONES: assert property (busy && st == spe_pkg::S_SRD && sck_fall |=> so)
		else $error("Status bit not one during write cycle");
	AST_PROT_MAP: assert property (mif.we |-> bp == 2'h0 || (bp == 2'h1 && mif.waddr < spe_pkg::PROT_QTR)
		|| (bp == 2'h2 && mif.waddr < spe_pkg::PROT_HALF))
		else $error("Write into protected range");
	AST_OPC_CAPTURE: assert property (s_opc_byte |=> opc == $past(in_byte))
		else $error("Opcode not captured");
	AST_SO_EDGE: assert property ($changed(so) |-> $past(pin_fall[spe_pkg::PIN_SCK]))
		else $error("Output changed off a falling edge");
	AST_WEL_CLEARED: assert property ($fell(busy) |-> !wel)
		else $error("Latch not cleared at completion");
	AST_WEL_SET: assert property (s_cs_end ##0 (st == spe_pkg::S_TAIL
		&& spe_pkg::spe_cmd_of(opc) == spe_pkg::C_SET) |=> wel)
		else $error("Latch not set");
	AST_BUSY_IGNORE: assert property (s_opc_byte ##0 (busy
		&& spe_pkg::spe_cmd_of(in_byte) != spe_pkg::C_SRD) |=> st == spe_pkg::S_IDLE)
		else $error("Command accepted while busy");
	AST_SR_GATE: assert property (s_cs_end ##0 (st == spe_pkg::S_SWR && (!wel || hwp)) |=> !busy)
		else $error("Status write not refused");
	AST_SR_HOLD: assert property (busy && bcnt != BW'(1) |=> $stable({protect_pin_enable, bp}))
		else $error("Status fields changed before completion");
	AST_RD_WRAP: assert property (byte_done && st == spe_pkg::S_ARD && addr == 18'h3ffff
		&& !pin_rise[spe_pkg::PIN_CS] |=> addr == 18'h00000)
		else $error("Read address did not wrap");
	AST_PAGE_STAY: assert property (byte_done && st == spe_pkg::S_AWR && !pin_rise[spe_pkg::PIN_CS]
		|=> addr[17:8] == $past(addr[17:8]))
		else $error("Write left its page");
	AST_IGNORE_OFF: assert property (st == spe_pkg::S_IDLE |-> so_oe_n)
		else $error("Output driven while ignoring");

endmodule // spe_eeprom_top

`default_nettype wire

//--- hw/spe_mem.sv
// Array storage: one synchronous read port, one write port.
// Assumes the controller holds the read address steady for the data it wants.
`timescale 1ns/1ps
`default_nettype none

module spe_mem #(
	parameter int AW = spe_pkg::ADDR_W
) (
	// Clock
	input wire logic clk,
	// Controller side
	spe_mem_if.mem   mp
);

	logic [7:0] store [2**AW];   // Byte array

	// ****************************************
	// Storage access
	// ****************************************
	// Write and read, read data registered
	always_ff @(posedge clk)
	begin
		if (mp.we)
		begin
			store[mp.waddr[AW-1:0]] <= mp.wdata;
		end
		mp.rdata <= store[mp.raddr[AW-1:0]];
	end

endmodule // spe_mem

`default_nettype wire

//--- hw/spe_mem_if.sv
// Carrier between the command logic and the array storage.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface spe_mem_if;
	logic [17:0] raddr;   // Read byte address
	logic [7:0]  rdata;   // Read data, one cycle after address
	logic        we;      // Write strobe
	logic [17:0] waddr;   // Write byte address
	logic [7:0]  wdata;   // Write data

	modport ctrl (output raddr, we, waddr, wdata, input rdata);
	modport mem  (input raddr, we, waddr, wdata, output rdata);
endinterface

`default_nettype wire

//--- hw/spe_pkg.sv
// Shared constants, types and decode helpers for the serial EEPROM command block.
// Assumes an 18-bit byte address space and a 25 MHz system clock.
`default_nettype none

package spe_pkg;

	// ****************************************
	// Geometry and timing
	// ****************************************
	localparam int          ADDR_W        = 18;           // Array byte address width
	localparam int          PAGE_BYTES    = 256;          // Page size in bytes
	localparam int          CLK_MHZ       = 25;           // System clock rate in MHz
	localparam int          TW_US         = 5000;         // Self-timed write time in us
	localparam int          TW_CYCLES_DEF = TW_US * CLK_MHZ; // Write time in clock cycles
	localparam logic [17:0] PROT_QTR      = 18'h30000;    // Start of quarter protected range
	localparam logic [17:0] PROT_HALF     = 18'h20000;    // Start of half protected range

	// ****************************************
	// Opcodes, compared after masking bit 3
	// ****************************************
	localparam logic [7:0] OP_MASK   = 8'hf7;
	localparam logic [7:0] OP_SETWEL = 8'h06;
	localparam logic [7:0] OP_CLRWEL = 8'h04;
	localparam logic [7:0] OP_SRD    = 8'h05;
	localparam logic [7:0] OP_SWR    = 8'h01;
	localparam logic [7:0] OP_ARD    = 8'h03;
	localparam logic [7:0] OP_AWR    = 8'h02;
	localparam logic [7:0] OP_IDRD   = 8'h83;
	localparam logic [7:0] OP_IDWR   = 8'h82;

	// ****************************************
	// Status layout and fixed read values
	// ****************************************
	localparam int         SR_RDY      = 0;       // Ready, low when idle
	localparam int         SR_WEL      = 1;       // Write enable latch
	localparam int         SR_BP0      = 2;       // Block protect low bit
	localparam int         SR_BP1      = 3;       // Block protect high bit
	localparam int         SR_PROTECT_PIN_ENABLE     = 7;       // Protect pin enable
	localparam logic [7:0] SR_BUSY_VAL = 8'hff;   // Status seen during write cycle
	localparam logic [7:0] ID_FILL     = 8'hff;   // Identification page read data
	localparam logic [7:0] LOCK_STAT   = 8'h00;   // Lock status read data
	localparam logic       PROTECT_PIN_ENABLE_RST    = 1'b0;    // Protect pin enable after reset
	localparam logic [1:0] BP_RST      = 2'h0;    // Block protect after reset
	localparam int         A10_POS     = 2;       // Bit 10 inside middle byte after shift

	// ****************************************
	// Pin order inside the synchroniser
	// ****************************************
	localparam int PIN_CS  = 0;
	localparam int PIN_SCK = 1;
	localparam int PIN_SI  = 2;
	localparam int PIN_WP  = 3;

	// Transaction states
	typedef enum logic [3:0] {S_IDLE, S_OPC, S_TAIL, S_SRD, S_SWR, S_ADDR, S_ARD, S_AWR, S_CRD} spe_state_e;

	// Decoded commands
	typedef enum logic [3:0] {C_NONE, C_SET, C_CLR, C_SRD, C_SWR, C_ARD, C_AWR, C_IRD, C_IWR} spe_cmd_e;

	// Opcode to command, bit 3 ignored
	function automatic spe_cmd_e spe_cmd_of(input logic [7:0] op);
		logic [7:0] m;
		m = op & OP_MASK;
		case (m)
			OP_SETWEL: return C_SET;
			OP_CLRWEL: return C_CLR;
			OP_SRD:    return C_SRD;
			OP_SWR:    return C_SWR;
			OP_ARD:    return C_ARD;
			OP_AWR:    return C_AWR;
			OP_IDRD:   return C_IRD;
			OP_IDWR:   return C_IWR;
			default:   return C_NONE;
		endcase
	endfunction

	// Address falls inside the block protected range
	function automatic logic spe_is_prot(input logic [17:0] a, input logic [1:0] bp);
		case (bp)
			2'h0:    return 1'b0;
			2'h1:    return a >= PROT_QTR;
			2'h2:    return a >= PROT_HALF;
			default: return 1'b1;
		endcase
	endfunction

endpackage

`default_nettype wire

//--- hw/spe_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes asynchronous pins; outputs are in the system clock domain.
`timescale 1ns/1ps
`default_nettype none

module spe_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Raw pins
	input  wire logic [W-1:0] din,
	// Filtered level and edges
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] s1, s2, s3;   // Synchroniser stages
	logic [W-1:0] next_lvl;     // Filtered level

	// Level changes only once stages two and three agree
	always_comb
	begin
		next_lvl = lvl;
		for (int i = 0; i < W; i++)
		begin
			if (s2[i] == s3[i])
			begin
				next_lvl[i] = s3[i];
			end
		end
	end

	// Stages, level and one-cycle edge pulses
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1   <= '1;
			s2   <= '1;
			s3   <= '1;
			lvl  <= '1;
			rise <= '0;
			fall <= '0;
		end
		else
		begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			lvl  <= next_lvl;
			rise <= ~lvl & next_lvl;
			fall <= lvl & ~next_lvl;
		end
	end

endmodule // spe_sync

`default_nettype wire
